// >>> rtl/timer8_pkg.sv
// constants shared by the 8-bit waveform timer
package timer8_pkg;
  // waveform select encodings
  localparam logic [1:0] WS_NORMAL      = 2'h0;
  localparam logic [1:0] WS_PHASE_PWM   = 2'h1;
  localparam logic [1:0] WS_CLEAR_MATCH = 2'h2;
  localparam logic [1:0] WS_FAST_PWM    = 2'h3;
  // compare output actions
  localparam logic [1:0] ACT_NONE   = 2'h0;
  localparam logic [1:0] ACT_TOGGLE = 2'h1;
  localparam logic [1:0] ACT_CLEAR  = 2'h2;
  localparam logic [1:0] ACT_SET    = 2'h3;
  // counter extremes
  localparam logic [7:0] CNT_BOTTOM = 8'h00;
  localparam logic [7:0] CNT_MAX    = 8'hff;
  // register byte offsets
  localparam logic [7:0] OFS_CTRL    = 8'h00;
  localparam logic [7:0] OFS_COUNT   = 8'h04;
  localparam logic [7:0] OFS_COMPARE = 8'h08;
  localparam logic [7:0] OFS_FLAGS   = 8'h0c;
  // control and flag field positions
  localparam int CTRL_WS_LSB    = 0;
  localparam int CTRL_ACT_LSB   = 2;
  localparam int CTRL_PRE_LSB   = 4;
  localparam int CTRL_DIR_BIT   = 7;
  localparam int FLAG_MATCH_BIT = 0;
  localparam int FLAG_OVF_BIT   = 1;
  // prescale select codes: 0 stops, 1..7 pick 1,8,32,64,128,256,1024
  localparam logic [2:0] PRE_STOP = 3'h0;
  localparam logic [9:0] PRE_DIV_1    = 10'h000;
  localparam logic [9:0] PRE_DIV_8    = 10'h007;
  localparam logic [9:0] PRE_DIV_32   = 10'h01f;
  localparam logic [9:0] PRE_DIV_64   = 10'h03f;
  localparam logic [9:0] PRE_DIV_128  = 10'h07f;
  localparam logic [9:0] PRE_DIV_256  = 10'h0ff;
  localparam logic [9:0] PRE_DIV_1024 = 10'h3ff;
  // ahb transfer types
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HTRANS_SEQ    = 2'h3;
endpackage : timer8_pkg

// >>> rtl/timer8_waveform_modes.sv
// 8-bit timer with one compare channel, four waveform modes, ahb-lite slave
//
// Chosen here: the placing of the registers and register access over AHB-Lite.
`timescale 1ns/100ps
`default_nettype none
module timer8_waveform_modes (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [7:0]  haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  output logic             compare_output,
  output logic             pin_out,
  output logic             pin_oe
);
  import timer8_pkg::*;

  typedef struct packed {
    logic [7:0] count_value;
    logic [7:0] compare_value;   // active compare
    logic [7:0] compare_buf;     // software-visible buffer
    logic [1:0] waveform_select;
    logic [1:0] compare_output_action;
    logic [2:0] prescale_sel;
    logic       dir_out;
    logic       count_down;
    logic       match_pend;      // equality seen, flag next cycle
    logic       block_match;     // count written, block next tick
    logic       compare_match_flag;
    logic       overflow_flag;
    logic       oc;
    logic [9:0] pre_cnt;
    logic       dph_wr;
    logic [7:0] dph_addr;
    logic [31:0] rdata;
  } state_s;

  state_s s_r;
  state_s s_nxt;

  logic       addr_ok;
  logic       tick;
  logic [9:0] pre_lim;
  logic       pwm;
  logic       eq;
  logic       match;
  logic       wr_count;
  logic       wr_cmp;
  logic       wr_ctrl;
  logic       wr_flag;
  logic [7:0] wd;
  logic       at_top;
  logic       bot_evt;
  logic       ovf_set;

  // prescale limit; selection 0 stops the timer
  always_comb begin
    unique case (s_r.prescale_sel)
      3'h1: pre_lim = PRE_DIV_1;
      3'h2: pre_lim = PRE_DIV_8;
      3'h3: pre_lim = PRE_DIV_32;
      3'h4: pre_lim = PRE_DIV_64;
      3'h5: pre_lim = PRE_DIV_128;
      3'h6: pre_lim = PRE_DIV_256;
      3'h7: pre_lim = PRE_DIV_1024;
      default: pre_lim = PRE_DIV_1;
    endcase
  end

  // prescaled tick; >= so a smaller divide picked mid-count needs no 10-bit wrap
  assign tick = (s_r.prescale_sel != PRE_STOP) && (s_r.pre_cnt >= pre_lim);

  // bus decode; address phase accepted when hready high
  assign addr_ok = hsel && hready && (htrans == HTRANS_NONSEQ || htrans == HTRANS_SEQ);
  assign wd       = hwdata[7:0];
  assign wr_ctrl  = s_r.dph_wr && s_r.dph_addr == OFS_CTRL;
  assign wr_count = s_r.dph_wr && s_r.dph_addr == OFS_COUNT;
  assign wr_cmp   = s_r.dph_wr && s_r.dph_addr == OFS_COMPARE;
  assign wr_flag  = s_r.dph_wr && s_r.dph_addr == OFS_FLAGS;

  assign pwm    = s_r.waveform_select == WS_PHASE_PWM || s_r.waveform_select == WS_FAST_PWM;
  assign eq     = s_r.count_value == s_r.compare_value;
  // write blocks the match of the next tick
  assign match  = tick && eq && !s_r.block_match;
  // top is compare value in mode 2, else MAX
  assign at_top = (s_r.waveform_select == WS_CLEAR_MATCH) ? eq : (s_r.count_value == CNT_MAX);
  assign bot_evt = tick && (s_r.count_value == CNT_BOTTOM) && s_r.count_down;

  // next-state logic
  always_comb begin
    s_nxt = s_r;
    s_nxt.rdata = 32'h0000_0000;
    ovf_set = 1'b0;
    s_nxt.pre_cnt = tick ? 10'h000 : s_r.pre_cnt + 10'h001;
    if (s_r.prescale_sel == PRE_STOP) begin
      s_nxt.pre_cnt = 10'h000;
    end
    // counter
    if (tick) begin
      s_nxt.match_pend = match;
      unique case (s_r.waveform_select)
        WS_NORMAL: s_nxt.count_value = s_r.count_value + 8'h01;
        // clear on match, otherwise wrap through 0xFF
        WS_CLEAR_MATCH: begin
          s_nxt.count_value = eq ? CNT_BOTTOM : s_r.count_value + 8'h01;
        end
        WS_FAST_PWM: begin
          s_nxt.count_value = s_r.count_value + 8'h01;
        end
        // dual slope over full eight bits
        WS_PHASE_PWM: begin
          if (!s_r.count_down && s_r.count_value == CNT_MAX) begin
            s_nxt.count_down  = 1'b1;
            s_nxt.count_value = CNT_MAX - 8'h01;
          end else if (s_r.count_down && s_r.count_value == CNT_BOTTOM) begin
            s_nxt.count_down  = 1'b0;
            s_nxt.count_value = CNT_BOTTOM + 8'h01;
          end else if (s_r.count_down) begin
            s_nxt.count_value = s_r.count_value - 8'h01;
          end else begin
            s_nxt.count_value = s_r.count_value + 8'h01;
          end
        end
      endcase
      if (s_r.waveform_select != WS_PHASE_PWM) begin
        s_nxt.count_down = 1'b0;
      end
      s_nxt.block_match = 1'b0;
    end else begin
      s_nxt.match_pend = 1'b0;
    end
    if (s_r.match_pend) begin
      s_nxt.compare_match_flag = 1'b1;
    end
    if (tick) begin
      unique case (s_r.waveform_select)
        WS_NORMAL, WS_CLEAR_MATCH: begin
          if (s_r.count_value == CNT_MAX) ovf_set = 1'b1;
        end
        WS_FAST_PWM: begin
          if (s_r.count_value == CNT_MAX - 8'h01) ovf_set = 1'b1;
        end
        WS_PHASE_PWM: begin
          if (s_r.count_down && s_r.count_value == CNT_BOTTOM + 8'h01) begin
            ovf_set = 1'b1;
          end
        end
      endcase
    end
    if (ovf_set) begin
      s_nxt.overflow_flag = 1'b1;
    end
    // buffered compare loads at MAX in both fast and phase (up-count) modes
    if (pwm && tick) begin
      if ((s_r.waveform_select == WS_FAST_PWM && s_r.count_value == CNT_MAX) ||
          (s_r.waveform_select == WS_PHASE_PWM && !s_r.count_down &&
           s_r.count_value == CNT_MAX)) begin
        s_nxt.compare_value = s_r.compare_buf;
      end
    end
    // waveform generator
    if (match) begin
      unique case (s_r.compare_output_action)
        ACT_NONE: s_nxt.oc = s_r.oc;
        ACT_TOGGLE: s_nxt.oc = ~s_r.oc;
        ACT_CLEAR, ACT_SET: begin
          // phase pwm, clear action: up-count match clears, down-count match sets; set action is the reverse
          if (s_r.waveform_select == WS_PHASE_PWM) begin
            s_nxt.oc = (s_r.count_down ^ (s_r.compare_output_action == ACT_SET));
          end else begin
            s_nxt.oc = (s_r.compare_output_action == ACT_SET);
          end
        end
      endcase
    end
    // fast pwm sets/clears at bottom; match at MAX wins
    if (tick && s_r.waveform_select == WS_FAST_PWM && s_r.count_value == CNT_MAX &&
        !match && s_r.compare_output_action[1]) begin
      s_nxt.oc = (s_r.compare_output_action == ACT_CLEAR);
    end
    // bus data phase writes
    if (wr_ctrl) begin
      s_nxt.waveform_select       = wd[CTRL_WS_LSB +: 2];
      s_nxt.compare_output_action = wd[CTRL_ACT_LSB +: 2];
      s_nxt.prescale_sel          = wd[CTRL_PRE_LSB +: 3];
      s_nxt.dir_out               = wd[CTRL_DIR_BIT];
    end
    if (wr_count) begin
      s_nxt.count_value = wd;
      // a match already seen on this tick still reaches the flag
      s_nxt.block_match = 1'b1;
    end
    if (wr_cmp) begin
      s_nxt.compare_buf = wd;
      if (!pwm) s_nxt.compare_value = wd;
    end
    // write one clears; a set in the same cycle wins
    if (wr_flag) begin
      if (wd[FLAG_MATCH_BIT] && !s_r.match_pend) s_nxt.compare_match_flag = 1'b0;
      // an overflow on this tick must not be lost to the clear, even if already high
      if (wd[FLAG_OVF_BIT] && !ovf_set) begin
        s_nxt.overflow_flag = 1'b0;
      end
    end
    // address phase capture and read data
    s_nxt.dph_wr   = addr_ok && hwrite;
    s_nxt.dph_addr = haddr;
    if (addr_ok && !hwrite) begin
      unique case (haddr)
        OFS_CTRL: begin
          s_nxt.rdata = {24'h00_0000, s_r.dir_out, s_r.prescale_sel,
                         s_r.compare_output_action, s_r.waveform_select};
        end
        OFS_COUNT:   s_nxt.rdata = {24'h00_0000, s_r.count_value};
        OFS_COMPARE: s_nxt.rdata = {24'h00_0000, s_r.compare_buf};
        OFS_FLAGS: begin
          s_nxt.rdata = {29'h0000_0000, s_r.oc, s_r.overflow_flag, s_r.compare_match_flag};
        end
        default: s_nxt.rdata = 32'h0000_0000;
      endcase
    end
  end

  // single state register; reset clears everything
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // outputs straight from flops or tied off; pin enable is the direction bit
  assign hrdata         = s_r.rdata;
  assign hreadyout      = 1'b1;
  assign hresp          = 1'b0;
  assign compare_output = s_r.oc;
  assign pin_out        = s_r.oc;
  assign pin_oe         = s_r.dir_out;

  // assertions
  property p_clear_match;
    @(posedge hclk) disable iff (!hresetn)
      (tick && s_r.waveform_select == WS_CLEAR_MATCH && eq && !wr_count)
      |=> (s_r.count_value == CNT_BOTTOM);
  endproperty
  a_clear_match: assert property (p_clear_match) else $error("counter not cleared on match");

  property p_flag_next;
    @(posedge hclk) disable iff (!hresetn)
      match |=> ##1 s_r.compare_match_flag;
  endproperty
  a_flag_next: assert property (p_flag_next) else $error("match flag not set");

  property p_block;
    @(posedge hclk) disable iff (!hresetn)
      (tick && eq && s_r.block_match) |=> !s_r.match_pend;
  endproperty
  a_block: assert property (p_block) else $error("match not blocked after count write");

  property p_pin_gate;
    @(posedge hclk) disable iff (!hresetn)
      wr_ctrl |=> (pin_oe == $past(wd[CTRL_DIR_BIT]));
  endproperty
  a_pin_gate: assert property (p_pin_gate) else $error("pin driven while input");

  property p_ovf_normal;
    @(posedge hclk) disable iff (!hresetn)
      (tick && s_r.waveform_select == WS_NORMAL && s_r.count_value == CNT_MAX && !wr_count)
      |=> (s_r.count_value == CNT_BOTTOM && s_r.overflow_flag);
  endproperty
  a_ovf_normal: assert property (p_ovf_normal) else $error("normal wrap without overflow");

  property p_phase_max;
    @(posedge hclk) disable iff (!hresetn)
      (tick && s_r.waveform_select == WS_PHASE_PWM && s_r.count_value == CNT_MAX &&
       !wr_count && !wr_ctrl) |=> (s_r.count_down && s_r.count_value == CNT_MAX - 8'h01);
  endproperty
  a_phase_max: assert property (p_phase_max) else $error("phase pwm did not turn at max");

  property p_fast_wrap;
    @(posedge hclk) disable iff (!hresetn)
      (tick && s_r.waveform_select == WS_FAST_PWM && s_r.count_value == CNT_MAX && !wr_count)
      |=> (s_r.count_value == CNT_BOTTOM);
  endproperty
  a_fast_wrap: assert property (p_fast_wrap) else $error("fast pwm did not restart");

  property p_toggle;
    @(posedge hclk) disable iff (!hresetn)
      (match && s_r.compare_output_action == ACT_TOGGLE) |=> (s_r.oc != $past(s_r.oc));
  endproperty
  a_toggle: assert property (p_toggle) else $error("output did not toggle");

  property p_ctc_ovf;
    @(posedge hclk) disable iff (!hresetn)
      (tick && s_r.waveform_select == WS_CLEAR_MATCH && s_r.count_value == CNT_MAX)
      |=> s_r.overflow_flag;
  endproperty
  a_ctc_ovf: assert property (p_ctc_ovf) else $error("clear mode wrap without overflow");

  property p_fast_ovf;
    @(posedge hclk) disable iff (!hresetn)
      (tick && s_r.waveform_select == WS_FAST_PWM && s_r.count_value == CNT_MAX - 8'h01 &&
       !wr_count) |=> (s_r.count_value == CNT_MAX && s_r.overflow_flag);
  endproperty
  a_fast_ovf: assert property (p_fast_ovf) else $error("fast pwm max without overflow");

  property p_phase_bottom;
    @(posedge hclk) disable iff (!hresetn)
      (tick && s_r.waveform_select == WS_PHASE_PWM && s_r.count_down &&
       s_r.count_value == CNT_BOTTOM + 8'h01 && !wr_count)
      |=> (s_r.count_value == CNT_BOTTOM && s_r.overflow_flag);
  endproperty
  a_phase_bottom: assert property (p_phase_bottom) else $error("phase bottom no overflow");

  property p_phase_turn_up;
    @(posedge hclk) disable iff (!hresetn)
      (tick && s_r.waveform_select == WS_PHASE_PWM && s_r.count_down &&
       s_r.count_value == CNT_BOTTOM && !wr_count)
      |=> (!s_r.count_down && s_r.count_value == CNT_BOTTOM + 8'h01);
  endproperty
  a_phase_turn_up: assert property (p_phase_turn_up) else $error("phase did not turn up");

  property p_buf_hold;
    @(posedge hclk) disable iff (!hresetn)
      (pwm && !(tick && s_r.count_value == CNT_MAX)) |=> $stable(s_r.compare_value);
  endproperty
  a_buf_hold: assert property (p_buf_hold) else $error("active compare moved mid-period");

  property p_fast_bottom;
    @(posedge hclk) disable iff (!hresetn)
      (tick && s_r.waveform_select == WS_FAST_PWM && s_r.count_value == CNT_MAX &&
       s_r.compare_value != CNT_MAX && s_r.compare_output_action == ACT_CLEAR)
      |=> s_r.oc;
  endproperty
  a_fast_bottom: assert property (p_fast_bottom) else $error("fast pwm not set at bottom");

  property p_phase_match;
    @(posedge hclk) disable iff (!hresetn)
      (match && s_r.waveform_select == WS_PHASE_PWM && s_r.compare_output_action == ACT_CLEAR)
      |=> (s_r.oc == $past(s_r.count_down));
  endproperty
  a_phase_match: assert property (p_phase_match) else $error("phase match level wrong");

  c_ctc:   cover property (@(posedge hclk) match && s_r.waveform_select == WS_CLEAR_MATCH);
  c_fast:  cover property (@(posedge hclk) tick && s_r.waveform_select == WS_FAST_PWM && at_top);
  c_phase: cover property (@(posedge hclk) bot_evt && s_r.waveform_select == WS_PHASE_PWM);
endmodule // timer8_waveform_modes
`default_nettype wire

// >>> verif/test_timer8_waveform_modes.sv
// self-checking bench for the 8-bit waveform timer
`timescale 1ns/100ps
`default_nettype none
module test_timer8_waveform_modes;
  import timer8_pkg::*;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic        compare_output, pin_out, pin_oe;
  logic [7:0]  haddr;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] hwdata, hrdata, q;
  int          fail_count, n_compared, hi, lo, d, c, n;

  timer8_waveform_modes timer8_waveform_modes_inst (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .compare_output(compare_output),
    .pin_out(pin_out), .pin_oe(pin_oe));

  // 250 MHz clock
  initial begin
    hclk = 1'b0;
    forever #2 hclk = ~hclk;
  end

  task automatic finish_test();
    $display("counts: compared %0d mismatched %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // one single ahb-lite transfer; hready is waited on, never assumed
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] dw,
                     output logic [31:0] dr);
    int k;
    @(posedge hclk);
    hsel   <= 1'b1;
    htrans <= HTRANS_NONSEQ;
    hwrite <= wr;
    haddr  <= a;
    // address phase stands until hready is seen high at an edge
    k = 0;
    do begin
      @(posedge hclk);
      k++;
    end while (hreadyout !== 1'b1 && k < 100);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= dw;
    // data phase needs its own edge; read data is taken at it
    do begin
      @(posedge hclk);
      k++;
    end while (hreadyout !== 1'b1 && k < 100);
    dr = hrdata;
    if (k >= 100) begin
      fail_count++;
      finish_test();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] dw);
    logic [31:0] x;
    bus(1'b1, a, dw, x);
  endtask

  // counts edges until compare_output shows v; bounded
  task automatic lvl_wait(input logic v, output int cnt);
    cnt = 0;
    while (compare_output !== v) begin
      @(posedge hclk);
      cnt++;
      if (cnt > 20000) begin fail_count++; finish_test(); end
    end
  endtask

  task automatic toggle_gap(output int gap);
    logic v;
    int   x;
    v = compare_output;
    lvl_wait(~v, x);
    lvl_wait(v, gap);
  endtask

  task automatic pwm(output int h, output int l);
    int x;
    lvl_wait(1'b0, x);
    lvl_wait(1'b1, x);
    lvl_wait(1'b0, h);
    lvl_wait(1'b1, l);
  endtask

  function automatic logic [31:0] ctl(input logic [1:0] ws, input logic [1:0] act,
                                      input logic [2:0] pre, input logic dir);
    return {24'h00_0000, dir, pre, act, ws};
  endfunction

  function automatic int div_of(input int p);
    int t[8] = '{0, 1, 8, 32, 64, 128, 256, 1024};
    return t[p];
  endfunction

  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 8'h00;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0000_0000;
    fail_count = 0;
    n_compared = 0;
    void'($urandom(45615));
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    // reset state of every register, one unmapped place among them
    for (int i = 0; i < 5; i++) begin
      bus(1'b0, 8'(i * 4), 32'h0000_0000, q);
      check("reg after reset", q, 32'h0000_0000);
    end
    check("pin_oe after reset", pin_oe, 1'b0);
    check("output after reset", compare_output, 1'b0);
    check("okay response", hresp, 1'b0);
    check("no wait state", hreadyout, 1'b1);
    $display("test reset done");
    // count write blocks the match on the following tick
    wr(OFS_COMPARE, 32'h0000_0030);
    wr(OFS_COUNT, 32'h0000_0030);
    wr(OFS_FLAGS, 32'h0000_0003);
    wr(OFS_CTRL, ctl(WS_NORMAL, ACT_NONE, 3'h1, 1'b0));
    // let a flag from the first tick have time to show before the read
    repeat (4) @(posedge hclk);
    bus(1'b0, OFS_FLAGS, 32'h0000_0000, q);
    check("match blocked", q[FLAG_MATCH_BIT], 1'b0);
    // past the wrap (208 ticks) and the next real match (257 ticks)
    repeat (260) @(posedge hclk);
    bus(1'b0, OFS_FLAGS, 32'h0000_0000, q);
    check("normal wrap flag", q[FLAG_OVF_BIT], 1'b1);
    wr(OFS_FLAGS, 32'h0000_0002);
    bus(1'b0, OFS_FLAGS, 32'h0000_0000, q);
    check("overflow cleared", q[FLAG_OVF_BIT], 1'b0);
    check("match kept", q[FLAG_MATCH_BIT], 1'b1);
    $display("test normal done");
    // clear-on-match toggle period at every prescale code 1 to 7
    for (int p = 1; p < 8; p++) begin
      c = $urandom_range(1, 5);
      wr(OFS_CTRL, ctl(WS_CLEAR_MATCH, ACT_TOGGLE, 3'h0, 1'b1));
      wr(OFS_COMPARE, 32'(c));
      wr(OFS_COUNT, 32'h0000_0000);
      wr(OFS_FLAGS, 32'h0000_0003);
      wr(OFS_CTRL, ctl(WS_CLEAR_MATCH, ACT_TOGGLE, 3'(p), p[0]));
      toggle_gap(n);
      check("clear mode gap", n, div_of(p) * (c + 1));
      check("pin enable", pin_oe, 1'(p[0]));
      if (p[0]) check("pin level", pin_out, compare_output);
      bus(1'b0, OFS_FLAGS, 32'h0000_0000, q);
      check("match flag", q[FLAG_MATCH_BIT], 1'b1);
    end
    // a top below the count is missed, so the counter wraps
    wr(OFS_CTRL, ctl(WS_CLEAR_MATCH, ACT_NONE, 3'h0, 1'b0));
    wr(OFS_COMPARE, 32'h0000_0010);
    wr(OFS_COUNT, 32'h0000_0040);
    wr(OFS_FLAGS, 32'h0000_0003);
    wr(OFS_CTRL, ctl(WS_CLEAR_MATCH, ACT_NONE, 3'h1, 1'b0));
    repeat (300) @(posedge hclk);
    bus(1'b0, OFS_FLAGS, 32'h0000_0000, q);
    check("missed top wraps", q[FLAG_OVF_BIT], 1'b1);
    $display("test clear mode done");
    // single-slope: toggle, non-inverting and inverting
    for (int a = 1; a < 4; a++) begin
      d = $urandom_range(10, 240);
      wr(OFS_COMPARE, 32'(d));
      wr(OFS_CTRL, ctl(WS_FAST_PWM, 2'(a), 3'h1, 1'b1));
      repeat (600) @(posedge hclk);
      if (a == 1) begin
        toggle_gap(n);
        check("fast toggle gap", n, 256);
      end else begin
        pwm(hi, lo);
        check("fast period", hi + lo, 256);
        check("fast high", hi, (a == 2) ? d + 1 : 255 - d);
      end
    end
    // compare at MAX holds the level constant
    wr(OFS_CTRL, ctl(WS_FAST_PWM, ACT_CLEAR, 3'h1, 1'b1));
    wr(OFS_COMPARE, 32'h0000_00ff);
    repeat (600) @(posedge hclk);
    n = 0;
    // the match at MAX wins over the bottom set, so non-inverting stays low
    repeat (300) begin
      @(negedge hclk);
      n += int'(compare_output !== 1'b0);
    end
    check("fast max constant", n, 0);
    $display("test fast pwm done");
    // dual-slope with both polarities
    for (int a = 2; a < 4; a++) begin
      d = $urandom_range(10, 240);
      wr(OFS_COMPARE, 32'(d));
      wr(OFS_CTRL, ctl(WS_PHASE_PWM, 2'(a), 3'h1, 1'b1));
      repeat (1100) @(posedge hclk);
      pwm(hi, lo);
      check("phase period", hi + lo, 510);
      check("phase high", hi, (a == 2) ? 2 * d : 510 - 2 * d);
    end
    wr(OFS_FLAGS, 32'h0000_0003);
    repeat (520) @(posedge hclk);
    bus(1'b0, OFS_FLAGS, 32'h0000_0000, q);
    check("phase bottom flag", q[FLAG_OVF_BIT], 1'b1);
    $display("test phase pwm done");
    // reset in mid-run, with the timer still counting
    @(posedge hclk);
    hresetn <= 1'b0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      bus(1'b0, 8'(i * 4), 32'h0000_0000, q);
      check("reg after mid reset", q, 32'h0000_0000);
    end
    check("pin_oe after mid reset", pin_oe, 1'b0);
    $display("test mid reset done");
    finish_test();
  end
endmodule // test_timer8_waveform_modes
`default_nettype wire
